// file: design/cwc_pkg.sv
// Package for the two-way write-through cache controller
// Functional notes
// - Two direct-mapped groups of 1024 longwords; one index selects a set.
// - Fill group chosen at random; no age or usage bits kept.
// - Write-through, no write allocation; cache never differs from memory.
// - One tag per aligned quadword block of two longwords.
// - Only high-order tag bits stored and compared; index and word implied.
// - Each lookup compares the incoming tag with both groups' tags.
// - Read hit returns the longword with no main memory access.
// - Read miss fetches whole quadword; requested longword forwarded on arrival.
// - Write miss leaves cache unchanged, longword goes to memory only.
// - Every write issues a memory write; cache waits only when a write or read miss meets a posted write still pending.
// - Address bits 11:3 select block, bit 2 selects even or odd longword.
// - Hit needs tag match on 29:12, valid set, no parity error.
// - First fill longword clears valid; second sets it only without errors.
package cwc_pkg;
	localparam int ADDR_W = 30;
	localparam int TAG_HI = 29;
	localparam int TAG_LO = 12;
	localparam int TAG_W = TAG_HI - TAG_LO + 1;
	localparam int IDX_HI = 11;
	localparam int IDX_LO = 3;
	localparam int IDX_W = IDX_HI - IDX_LO + 1;
	localparam int WORD_BIT = 2;
	localparam int NUM_WAYS = 2;
	localparam int LW_PER_GROUP = 1024;
	localparam int NUM_SETS = LW_PER_GROUP / 2;
	localparam int LWI_W = IDX_W + 1;
	localparam int DATA_W = 32;
	localparam int MASK_W = DATA_W / 8;
	localparam int LFSR_W = 8;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 8'hA5;
	localparam logic [LFSR_W-1:0] LFSR_TAPS = 8'hB8;
	localparam logic BEAT_EVEN = 1'h0;
	localparam logic BEAT_ODD = 1'h1;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FILL_REQ,
		ST_FILL_DATA
	} cwc_fsm_t;

	typedef struct packed {
		cwc_fsm_t st;
		logic [ADDR_W-1:0] lat_addr;
		logic way;
		logic beat;
		logic fill_bad;
		logic rd_valid;
		logic rd_err;
		logic [DATA_W-1:0] rd_data;
		logic wb_full;
		logic [ADDR_W-1:0] wb_addr;
		logic [DATA_W-1:0] wb_data;
		logic [MASK_W-1:0] wb_mask;
	} cwc_state_t;
endpackage

// file: design/cwc_rand.sv
// Free-running pseudo-random bit for group replacement
`timescale 1ns/1ps
`default_nettype none
module cwc_rand import cwc_pkg::*; (
	input wire logic ref_clk,
	input wire logic sys_rst,
	output logic rand_bit
);
	typedef struct packed {
		logic [LFSR_W-1:0] lfsr;
	} cwc_rand_t;

	cwc_rand_t cur;
	cwc_rand_t next_cur;

	// =====================================================
	// Galois LFSR, never stops so samples look uncorrelated
	always_comb begin
		next_cur = cur;
		if (cur.lfsr[0]) begin
			next_cur.lfsr = (cur.lfsr >> 1) ^ LFSR_TAPS;
		end else begin
			next_cur.lfsr = cur.lfsr >> 1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cur.lfsr <= LFSR_SEED;
		end else begin
			cur <= next_cur;
		end
	end

	assign rand_bit = cur.lfsr[0];

	lfsr_alive_a: assert property (@(posedge ref_clk)
		disable iff (sys_rst)
		cur.lfsr != '0) else $error("lfsr locked at zero");
endmodule
`default_nettype wire

// file: design/cwc_cache.sv
// Two-way set-associative write-through cache controller
`timescale 1ns/1ps
`default_nettype none
module cwc_cache import cwc_pkg::*; (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] physical_address_bus,
	input wire logic [DATA_W-1:0] memory_data_bus_wr,
	input wire logic [MASK_W-1:0] req_byte_mask,
	output logic req_ready,
	output logic rd_valid,
	output logic rd_err,
	output logic [DATA_W-1:0] memory_data_bus_rd,
	output logic mem_rd_req,
	input wire logic mem_rd_ready,
	output logic [ADDR_W-1:0] mem_rd_addr,
	input wire logic mem_fill_valid,
	input wire logic [DATA_W-1:0] mem_fill_data,
	input wire logic mem_fill_err,
	output logic mem_wr_valid,
	input wire logic mem_wr_ready,
	output logic [ADDR_W-1:0] mem_wr_addr,
	output logic [DATA_W-1:0] mem_wr_data,
	output logic [MASK_W-1:0] mem_wr_mask
);
	// =====================================================
	// Helpers
	function automatic logic [IDX_W-1:0] idx_of(logic [ADDR_W-1:0] a);
		return a[IDX_HI:IDX_LO];
	endfunction

	function automatic logic [LWI_W-1:0] lwi_of(logic [ADDR_W-1:0] a);
		return {a[IDX_HI:IDX_LO], a[WORD_BIT]};
	endfunction

	function automatic logic [TAG_W-1:0] tag_of(logic [ADDR_W-1:0] a);
		return a[TAG_HI:TAG_LO];
	endfunction

	// =====================================================
	// Matrices; valid bits alone are reset
	logic [DATA_W-1:0] data_g [NUM_WAYS][LW_PER_GROUP];
	logic dpar_g [NUM_WAYS][LW_PER_GROUP];
	logic [TAG_W-1:0] tag_g [NUM_WAYS][NUM_SETS];
	logic tpar_g [NUM_WAYS][NUM_SETS];
	logic [NUM_SETS-1:0] valid_g [NUM_WAYS];

	cwc_state_t cur;
	cwc_state_t next_cur;
	logic rand_bit;
	logic [NUM_WAYS-1:0] match;
	logic [DATA_W-1:0] rdw [NUM_WAYS];
	logic hit;
	logic hit_way;
	logic take;
	logic data_we;
	logic data_way;
	logic [LWI_W-1:0] data_idx;
	logic [DATA_W-1:0] data_val;
	logic tag_we;
	logic valid_we;
	logic valid_val;
	logic [DATA_W-1:0] merged;

	cwc_rand u_rand (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.rand_bit(rand_bit)
	);

	// =====================================================
	// Lookup across both groups
	genvar g;
	generate
		for (g = 0; g < NUM_WAYS; g++) begin : gen_way
			logic [TAG_W-1:0] st_tag;
			logic tag_ok;
			logic dat_ok;
			assign st_tag = tag_g[g][idx_of(physical_address_bus)];
			assign rdw[g] = data_g[g][lwi_of(physical_address_bus)];
			assign tag_ok = (^{1'h1, st_tag}) ==
				tpar_g[g][idx_of(physical_address_bus)];
			assign dat_ok = (^rdw[g]) ==
				dpar_g[g][lwi_of(physical_address_bus)];
			assign match[g] = valid_g[g][idx_of(physical_address_bus)] &&
				(st_tag == tag_of(physical_address_bus)) &&
				tag_ok && dat_ok;
		end
	endgenerate

	assign hit = |match;
	assign hit_way = match[1];
	assign req_ready = (cur.st == ST_IDLE) && (!req_write || !cur.wb_full);
	assign take = req_valid && req_ready;

	// Byte-masked merge so a partial write hit keeps cache equal to memory
	always_comb begin
		merged = rdw[hit_way];
		for (int b = 0; b < MASK_W; b++) begin
			if (req_byte_mask[b]) begin
				merged[b*8 +: 8] = memory_data_bus_wr[b*8 +: 8];
			end
		end
	end

	// =====================================================
	// Controller
	always_comb begin
		next_cur = cur;
		next_cur.rd_valid = 1'h0;
		next_cur.rd_err = 1'h0;
		data_we = 1'h0;
		data_way = cur.way;
		data_idx = {idx_of(cur.lat_addr), cur.beat};
		data_val = mem_fill_data;
		tag_we = 1'h0;
		valid_we = 1'h0;
		valid_val = 1'h0;
		if (cur.wb_full && mem_wr_ready) begin
			next_cur.wb_full = 1'h0;
		end
		case (cur.st)
			ST_IDLE: begin
				if (take && req_write) begin
					next_cur.wb_full = 1'h1;
					next_cur.wb_addr = physical_address_bus;
					next_cur.wb_data = memory_data_bus_wr;
					next_cur.wb_mask = req_byte_mask;
					if (hit) begin
						data_we = 1'h1;
						data_way = hit_way;
						data_idx = lwi_of(physical_address_bus);
						data_val = merged;
					end // a miss touches nothing here
				end else if (take && hit) begin
					next_cur.rd_valid = 1'h1;
					next_cur.rd_data = rdw[hit_way];
				end else if (take) begin
					next_cur.st = ST_FILL_REQ;
					next_cur.lat_addr = physical_address_bus;
					next_cur.way = rand_bit;
					next_cur.beat = BEAT_EVEN;
					next_cur.fill_bad = 1'h0;
				end
			end
			ST_FILL_REQ: begin
				if (mem_rd_req && mem_rd_ready) begin
					next_cur.st = ST_FILL_DATA;
				end
			end
			ST_FILL_DATA: begin
				if (mem_fill_valid) begin
					data_we = 1'h1;
					valid_we = 1'h1;
					next_cur.beat = BEAT_ODD;
					next_cur.fill_bad = cur.fill_bad | mem_fill_err;
					if (cur.beat == BEAT_ODD) begin
						tag_we = 1'h1;
						valid_val = !(cur.fill_bad | mem_fill_err);
						next_cur.st = ST_IDLE;
					end
					if (cur.beat == cur.lat_addr[WORD_BIT]) begin
						next_cur.rd_valid = 1'h1;
						next_cur.rd_err = mem_fill_err;
						next_cur.rd_data = mem_fill_data;
					end
				end
			end
			default: begin
				next_cur.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// =====================================================
	// Matrix writes
	always_ff @(posedge ref_clk) begin
		if (data_we) begin
			data_g[data_way][data_idx] <= data_val;
			dpar_g[data_way][data_idx] <= ^data_val;
		end
		if (tag_we) begin
			tag_g[cur.way][idx_of(cur.lat_addr)] <= tag_of(cur.lat_addr);
			tpar_g[cur.way][idx_of(cur.lat_addr)] <=
				^{1'h1, tag_of(cur.lat_addr)};
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int w = 0; w < NUM_WAYS; w++) begin
				valid_g[w] <= '0;
			end
		end else if (valid_we) begin
			valid_g[cur.way][idx_of(cur.lat_addr)] <= valid_val;
		end
	end

	// =====================================================
	// Outputs; reads wait for posted write so memory order holds
	assign mem_rd_req = (cur.st == ST_FILL_REQ) && !cur.wb_full;
	assign mem_rd_addr = {cur.lat_addr[ADDR_W-1:IDX_LO], 3'h0};
	assign mem_wr_valid = cur.wb_full;
	assign mem_wr_addr = cur.wb_addr;
	assign mem_wr_data = cur.wb_data;
	assign mem_wr_mask = cur.wb_mask;
	assign rd_valid = cur.rd_valid;
	assign rd_err = cur.rd_err;
	assign memory_data_bus_rd = cur.rd_data;

	logic fill_vld;
	assign fill_vld = valid_g[cur.way][idx_of(cur.lat_addr)];

	rd_hit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && !req_write && hit |=> rd_valid && !rd_err && !mem_rd_req)
		else $error("read hit not answered");
	wr_post_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && req_write |=> mem_wr_valid &&
		mem_wr_data == $past(memory_data_bus_wr) &&
		mem_wr_addr == $past(physical_address_bus))
		else $error("write not posted");
	no_alloc_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && req_write && !hit |-> !data_we ##1 cur.st == ST_IDLE)
		else $error("write miss allocated");
	miss_fill_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && !req_write && !hit |=> cur.st == ST_FILL_REQ &&
		cur.way == $past(rand_bit)) else $error("read miss not filled");
	rd_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mem_rd_req |-> !mem_wr_valid) else $error("read passed write");
	first_inv_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		cur.st == ST_FILL_DATA && mem_fill_valid && cur.beat == BEAT_EVEN
		|=> !fill_vld) else $error("first fill word left valid");
	second_val_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		cur.st == ST_FILL_DATA && mem_fill_valid && cur.beat == BEAT_ODD
		|=> fill_vld == !$past(cur.fill_bad | mem_fill_err))
		else $error("second fill word valid wrong");
	fwd_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		cur.st == ST_FILL_DATA && mem_fill_valid &&
		cur.beat == cur.lat_addr[WORD_BIT] |=> rd_valid &&
		memory_data_bus_rd == $past(mem_fill_data))
		else $error("requested word not forwarded");
	one_match_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(&match)) else $error("both groups hit");
endmodule
`default_nettype wire

// file: tb/cwc_mem_model.sv
// Backplane memory model answering fills and posted writes
`timescale 1ns/1ps
`default_nettype none
module cwc_mem_model import cwc_pkg::*; (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic inject_err,
	input wire logic mem_rd_req,
	output logic mem_rd_ready,
	input wire logic [ADDR_W-1:0] mem_rd_addr,
	output logic mem_fill_valid,
	output logic [DATA_W-1:0] mem_fill_data,
	output logic mem_fill_err,
	input wire logic mem_wr_valid,
	output logic mem_wr_ready,
	input wire logic [ADDR_W-1:0] mem_wr_addr,
	input wire logic [DATA_W-1:0] mem_wr_data,
	input wire logic [MASK_W-1:0] mem_wr_mask,
	output int n_fill,
	output int n_wr
);
	// ==========
	// Storage
	logic [DATA_W-1:0] mem [logic [27:0]];
	logic [DATA_W-1:0] w;
	logic [ADDR_W-1:0] fa;
	logic go;
	int ph;
	int cnt;
	function automatic logic [DATA_W-1:0] rd(input logic [27:0] k);
		return mem.exists(k) ? mem[k] : {k, 4'h0} ^ 32'h3C96A5F1;
	endfunction
	// ==========
	// Handshakes; slow mode gives ready only every fourth cycle, fill words in three cycles of four
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_rd_ready <= 1'b0;
			mem_wr_ready <= 1'b0;
			mem_fill_valid <= 1'b0;
			mem_fill_err <= 1'b0;
			mem_fill_data <= 32'h0;
			ph = 0;
			cnt = 0;
			n_fill = 0;
			n_wr = 0;
		end else begin
			cnt++;
			go = !slow || (cnt % 4 == 0);
			mem_rd_ready <= 1'b0;
			mem_wr_ready <= 1'b0;
			mem_fill_valid <= 1'b0;
			mem_fill_err <= 1'b0;
			// Idle data toggles so a stale word never looks valid
			mem_fill_data <= ~mem_fill_data;
			if (mem_wr_valid && mem_wr_ready) begin
				w = rd(mem_wr_addr[29:2]);
				for (int b = 0; b < 4; b++) begin
					if (mem_wr_mask[b]) w[8*b+:8] = mem_wr_data[8*b+:8];
				end
				mem[mem_wr_addr[29:2]] = w;
				n_wr++;
			end else if (mem_wr_valid && go) begin
				mem_wr_ready <= 1'b1;
			end
			if (ph == 0 && mem_rd_req && mem_rd_ready) begin
				fa = mem_rd_addr;
				ph = 1;
				n_fill++;
			end else if (ph == 0 && mem_rd_req && go) begin
				mem_rd_ready <= 1'b1;
			end else if (ph != 0 && (go || cnt[0])) begin
				mem_fill_valid <= 1'b1;
				mem_fill_data <= rd({fa[29:3], ph == 2});
				mem_fill_err <= inject_err && ph == 2;
				ph = (ph == 2) ? 0 : 2;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/tb_two_way_write_through_cache.sv
// Testbench for the two-way write-through cache controller
`timescale 1ns/1ps
`default_nettype none
module tb_two_way_write_through_cache import cwc_pkg::*; ;
	logic ref_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0;
	logic [29:0] pa = 0;
	logic [31:0] wd = 0;
	logic [3:0] bm = 0;
	logic slow = 0, inject_err = 0;
	logic req_ready, rd_valid, rd_err, mem_rd_req, mem_rd_ready;
	logic mem_fill_valid, mem_fill_err, mem_wr_valid, mem_wr_ready;
	logic [29:0] mem_rd_addr, mem_wr_addr;
	logic [31:0] rdat, mem_fill_data, mem_wr_data;
	logic [3:0] mem_wr_mask;
	logic [31:0] ref_mem [logic [27:0]];
	int n_fill, n_wr, error_cnt = 0, n_tests = 0, nw = 0, cyc = 0;
	int seed = 32'ha21f01dd;
	logic [LFSR_W-1:0] lfsr_m;
	logic [17:0] rtag [2][512];
	bit rvld [2][512];
	bit tk_way;
	cwc_cache i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.req_valid(req_valid), .req_write(req_write),
		.physical_address_bus(pa), .memory_data_bus_wr(wd),
		.req_byte_mask(bm), .req_ready(req_ready), .rd_valid(rd_valid),
		.rd_err(rd_err), .memory_data_bus_rd(rdat),
		.mem_rd_req(mem_rd_req), .mem_rd_ready(mem_rd_ready),
		.mem_rd_addr(mem_rd_addr), .mem_fill_valid(mem_fill_valid),
		.mem_fill_data(mem_fill_data), .mem_fill_err(mem_fill_err),
		.mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
		.mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
		.mem_wr_mask(mem_wr_mask));
	cwc_mem_model i_mem (.ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow),
		.inject_err(inject_err), .mem_rd_req(mem_rd_req),
		.mem_rd_ready(mem_rd_ready), .mem_rd_addr(mem_rd_addr),
		.mem_fill_valid(mem_fill_valid), .mem_fill_data(mem_fill_data),
		.mem_fill_err(mem_fill_err), .mem_wr_valid(mem_wr_valid),
		.mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data), .mem_wr_mask(mem_wr_mask),
		.n_fill(n_fill), .n_wr(n_wr));
	// ==========
	// Clock and hang guard
	always #2.5 ref_clk = ~ref_clk;
	// Replacement bit model; without it a hit after two fills is a guess
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) lfsr_m <= LFSR_SEED;
		else if (lfsr_m[0]) lfsr_m <= (lfsr_m >> 1) ^ LFSR_TAPS;
		else lfsr_m <= lfsr_m >> 1;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	// ==========
	// Tasks
	function automatic logic [31:0] mval(input logic [27:0] k);
		return ref_mem.exists(k) ? ref_mem[k] : {k, 4'h0} ^ 32'h3C96A5F1;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic issue(input logic w, input logic [29:0] a,
		input logic [31:0] d, input logic [3:0] m);
		int t;
		req_valid <= 1'b1;
		req_write <= w;
		pa <= a;
		wd <= d;
		bm <= m;
		t = 0;
		do begin @(negedge ref_clk); t++; end
		while (req_ready !== 1'b1 && t < 300);
		// Value the controller samples at the coming take edge
		tk_way = lfsr_m[0];
		@(posedge ref_clk);
		req_valid <= 1'b0;
	endtask
	// Hit expectation comes from the bench's own tag model
	task automatic rd(input logic [29:0] a, input logic err);
		int f;
		int t;
		logic ht;
		ht = 1'b0;
		for (int w = 0; w < 2; w++) begin
			ht = ht | (rvld[w][a[11:3]] &&
				rtag[w][a[11:3]] == a[29:12]);
		end
		f = n_fill;
		issue(1'b0, a, 32'h0, 4'h0);
		if (!ht) begin
			rtag[tk_way][a[11:3]] = a[29:12];
			rvld[tk_way][a[11:3]] = !inject_err;
		end
		t = 0;
		do begin @(negedge ref_clk); t++; end
		while (rd_valid !== 1'b1 && t < 300);
		chk(rdat, mval(a[29:2]));
		chk({31'h0, rd_err}, {31'h0, err});
		chk(32'(n_fill == f), 32'(ht));
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [29:0] a, input logic [31:0] d,
		input logic [3:0] m);
		logic [31:0] v;
		v = mval(a[29:2]);
		for (int b = 0; b < 4; b++) if (m[b]) v[8*b+:8] = d[8*b+:8];
		ref_mem[a[29:2]] = v;
		nw++;
		issue(1'b1, a, d, m);
		@(posedge ref_clk);
	endtask
	task automatic finish_test();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ==========
	// Main sequence
	initial begin
		logic [29:0] a;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 150; i++) begin
			a = {16'h0, 2'($random(seed)), 7'h0, 2'($random(seed)),
				1'($random(seed)), 2'b0};
			slow <= 1'($random(seed));
			if ($random(seed) % 3 == 0) begin
				wr(a, $random(seed), 4'($random(seed)));
			end else begin
				rd(a, 1'b0);
			end
		end
		$display("test random done");
		slow <= 1'b1;
		rd(30'h5048, 0);
		rd(30'h504C, 0);
		wr(30'h5048, 32'hC0DE1234, 4'h5);
		rd(30'h5048, 0);
		rd(30'h6048, 0);
		rd(30'h5048, 0);
		rd(30'h6048, 0);
		wr(30'h7048, 32'h89ABCDEF, 4'hF);
		rd(30'h5048, 0);
		rd(30'h6048, 0);
		rd(30'h7048, 0);
		$display("test hit and miss done");
		inject_err <= 1'b1;
		rd(30'h8054, 1);
		inject_err <= 1'b0;
		rd(30'h8054, 0);
		rd(30'h8054, 0);
		$display("test fill error done");
		repeat (30) @(posedge ref_clk);
		chk(n_wr, nw);
		finish_test();
	end
endmodule
`default_nettype wire
